// *** verilog/mis_map.svh ***
// Register offsets, reset values, vectors and wake masks of the interrupt sequencer
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH
`define MIS_OFF_CTRL 8'h00
`define MIS_OFF_SENS 8'h04
`define MIS_OFF_PEN 8'h08
`define MIS_OFF_PEND 8'h0c
`define MIS_OFF_VEC 8'h10
`define MIS_CTRL_MASK_BIT 0
`define MIS_RST_MASK 1'b1
`define MIS_RST_SENS 10'h000
`define MIS_RST_PEN 6'h00
`define MIS_PEND_PER_LSB 5
`define MIS_VEC_RESET 16'hfffe
`define MIS_VEC_TRAP 16'hfffc
`define MIS_VEC_BASE 16'hfffa
`define MIS_VEC_LOW 16'hffe0
`define MIS_SENS_FALL_LOW 2'h0
`define MIS_SENS_RISE 2'h1
`define MIS_SENS_FALL 2'h2
`define MIS_SENS_BOTH 2'h3
`define MIS_VN_EI2 4'h3
`define MIS_WAKE_WAIT 14'h3fff
`define MIS_WAKE_HALT 14'h002e
`define MIS_WAKE_AHALT 14'h0a6e
`define MIS_WAKE_AUTO_WAKEUP_FROM_HALT_MODE 14'h002f
`endif

// *** verilog/mis_pkg.sv ***
// Types shared by the interrupt sequencer and its users
package mis_pkg;
	typedef enum logic [1:0] {
		MIS_IDLE = 2'h0,
		MIS_SAVE = 2'h1,
		MIS_MASK = 2'h3,
		MIS_FETCH = 2'h2
	} mis_seq_e;
	typedef enum logic [2:0] {
		MIS_RUN = 3'h0,
		MIS_WAIT = 3'h1,
		MIS_HALT = 3'h2,
		MIS_AHALT = 3'h3,
		MIS_AUTO_WAKEUP_FROM_HALT_MODE = 3'h4
	} mis_mode_e;
	typedef struct packed {
		logic instr_boundary;
		logic trap_exec;
		logic return_from_interrupt;
		logic stack_done;
		logic vec_done;
	} mis_core_s;
endpackage : mis_pkg

// *** verilog/mis_seq.sv ***
// Interrupt latch, priority, entry sequencer and wake logic of the 8-bit core
`timescale 1ns/1ps
`include "mis_map.svh"
// Functional notes
// - Maskable requests are taken only while the global mask bit is clear.
// - Global mask bit is set out of reset.
// - Entry: finish instruction, save stack, set mask, then load vector.
// - Return from interrupt restores registers and clears the mask bit.
// - Lowest vector number pending wins.
// - Reset FFFE, trap FFFC, vectors 0..13 descend to FFE0.
// - Software trap is entered whatever the mask bit.
// - External request vectored when occurred and unmasked; externals zero to three wake from Halt.
// - Edge request latched, cleared on entering its service routine.
// - Low level on a combined port input blocks that source's request.
// - Peripheral flag requests only when enabled and unmasked, else stays pending.
// - Peripheral pending cleared by zero write or clear sequence; discards pending.
// - Every source wakes the core from Wait.
// - Auto-wakeup wakes only from Wait and auto-wakeup-from-halt mode.
// - Falling edge on external two never wakes from halt modes.
// - External four wakes only from Wait and Active-halt.
// - Timer overflow and timebase wake only from Wait and Active-halt.
// - Trap, supply warning, compare, capture never wake from Halt.
// - Sensitivity codes: 00 fall+low, 01 rise, 10 fall, 11 both.
// - Changing a sensitivity field clears that source's pending request.
// - Supply warning requests when flag, enable set and mask clear.
module mis_seq #(
	parameter int NUM_EXT = 5,
	parameter int NUM_PER = 6
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire mis_pkg::mis_core_s core,
	input wire mis_pkg::mis_mode_e power_mode,
	input wire logic [NUM_EXT-1:0] ext_irq_pin,
	input wire logic [NUM_EXT-1:0] port_low_pin,
	input wire logic [NUM_PER-1:0] periph_flag,
	input wire logic [NUM_PER-1:0] periph_clr,
	output logic global_mask,
	output logic stack_save_req,
	output logic vec_valid,
	output logic [15:0] vec_addr,
	output logic wake
);
	// The vector map is fixed; other counts cannot be served
	if (NUM_EXT != 5 || NUM_PER != 6) begin : g_chk
		$error("mis_seq supports exactly 5 external and 6 peripheral sources");
	end

	logic rst_q1;
	logic rst_n_sync;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_q1 <= 1'b0;
			rst_n_sync <= 1'b0;
		end else if (clk_en) begin
			rst_q1 <= 1'b1;
			rst_n_sync <= rst_q1;
		end
	end

	logic [NUM_EXT-1:0] ext_s1, ext_s2, ext_s3, blk_s1, blk_s2;
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ext_s1 <= '1;
			ext_s2 <= '1;
			ext_s3 <= '1;
			blk_s1 <= '0;
			blk_s2 <= '0;
		end else if (clk_en) begin
			ext_s1 <= ext_irq_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			blk_s1 <= ~port_low_pin;
			blk_s2 <= blk_s1;
		end
	end

	mis_pkg::mis_seq_e state, next_state;
	logic [9:0] sens;
	logic [NUM_PER-1:0] per_en, per_pend, flag_q;
	logic [NUM_EXT-1:0] ext_pend, ext_set, ext_clr, ext_fall, sens_chg;
	logic ext2_rise;
	logic [13:0] req_vec, wake_ok;
	logic [3:0] sel_vn, cur_vn;
	logic cur_trap;
	logic take, take_int;
	logic ap_valid, ap_write;
	logic [7:0] ap_addr;
	logic wr_ctrl, wr_sens, wr_pen, wr_pend;

	// AHB-Lite address phase capture; data phase writes use hwdata
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= 8'h00;
		end else if (clk_en) begin
			if (hready) begin
				ap_valid <= hsel && htrans[1];
				ap_write <= hwrite;
				ap_addr <= haddr[7:0];
			end
		end
	end
	assign wr_ctrl = ap_valid && ap_write && ap_addr == `MIS_OFF_CTRL;
	assign wr_sens = ap_valid && ap_write && ap_addr == `MIS_OFF_SENS;
	assign wr_pen = ap_valid && ap_write && ap_addr == `MIS_OFF_PEN;
	assign wr_pend = ap_valid && ap_write && ap_addr == `MIS_OFF_PEND;

	// Reads insert one wait state so a read right after a write sees the new value
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else if (clk_en) begin
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (!hreadyout) begin
				hreadyout <= 1'b1;
				case (ap_addr)
					`MIS_OFF_CTRL: hrdata <= {31'h0, global_mask};
					`MIS_OFF_SENS: hrdata <= {22'h0, sens};
					`MIS_OFF_PEN: hrdata <= {26'h0, per_en};
					`MIS_OFF_PEND: hrdata <= {21'h0, per_pend, ext_pend};
					`MIS_OFF_VEC: hrdata <= {14'h0, state, vec_addr};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Sensitivity may only change while the mask bit is set
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			sens <= `MIS_RST_SENS;
		end else if (clk_en) begin
			if (wr_sens && global_mask) begin
				sens <= hwdata[9:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			per_en <= `MIS_RST_PEN;
		end else if (clk_en) begin
			if (wr_pen) begin
				per_en <= hwdata[NUM_PER-1:0];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_EXT; i++) begin
			case (sens[2*i +: 2])
				`MIS_SENS_FALL_LOW: ext_fall[i] = ext_s3[i] | ~ext_s2[i];
				`MIS_SENS_RISE: ext_fall[i] = 1'b0;
				`MIS_SENS_FALL: ext_fall[i] = ext_s3[i] & ~ext_s2[i];
				default: ext_fall[i] = ext_s3[i] & ~ext_s2[i];
			endcase
			ext_set[i] = ext_fall[i] & ~ext_s2[i];
			if (sens[2*i +: 2] == `MIS_SENS_RISE || sens[2*i +: 2] == `MIS_SENS_BOTH) begin
				ext_set[i] = ext_set[i] | (ext_s2[i] & ~ext_s3[i]);
			end
			// low port input blocks the combined source
			ext_set[i] = ext_set[i] & ~blk_s2[i];
			// a changed field drops the pending request
			sens_chg[i] = wr_sens && global_mask && hwdata[2*i +: 2] != sens[2*i +: 2];
		end
	end

	// entry into the routine clears the external latch
	always_comb begin
		ext_clr = sens_chg;
		if (state == mis_pkg::MIS_MASK && !cur_trap) begin
			ext_clr[0] = ext_clr[0] | (cur_vn == 4'h1);
			ext_clr[1] = ext_clr[1] | (cur_vn == 4'h2);
			ext_clr[2] = ext_clr[2] | (cur_vn == 4'h3);
			ext_clr[3] = ext_clr[3] | (cur_vn == 4'h5);
			ext_clr[4] = ext_clr[4] | (cur_vn == 4'h6);
		end
	end

	// latches set in any power mode; a new event wins over a clear
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ext_pend <= '0;
			ext2_rise <= 1'b0;
		end else if (clk_en) begin
			ext_pend <= ext_set | (ext_pend & ~ext_clr);
			// remember whether external two came from a rising edge
			if (ext_set[2]) begin
				ext2_rise <= ~ext_fall[2];
			end else if (ext_clr[2]) begin
				ext2_rise <= 1'b0;
			end
		end
	end

	// zero write or clear sequence discards the pending request
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			flag_q <= '0;
			per_pend <= '0;
		end else if (clk_en) begin
			flag_q <= periph_flag;
			per_pend <= (periph_flag & ~flag_q) | (per_pend & ~periph_clr &
				~({NUM_PER{wr_pend}} & ~hwdata[`MIS_PEND_PER_LSB +: NUM_PER]));
		end
	end

	// peripheral requests need their enable; the mask gates the take
	assign req_vec = {2'b00, per_pend[5:1] & per_en[5:1], ext_pend[4:3], 1'b0,
		ext_pend[2:0], per_pend[0] & per_en[0]};

	always_comb begin
		sel_vn = 4'hf;
		for (int n = 13; n >= 0; n--) begin
			if (req_vec[n]) begin
				sel_vn = 4'(n);
			end
		end
	end

	// decide only at an instruction boundary
	assign take_int = |req_vec && !global_mask;
	assign take = state == mis_pkg::MIS_IDLE && core.instr_boundary &&
		(core.trap_exec || take_int);

	// save, mask, vector fetch in that order
	always_comb begin
		case (state)
			mis_pkg::MIS_IDLE: next_state = take ? mis_pkg::MIS_SAVE : mis_pkg::MIS_IDLE;
			mis_pkg::MIS_SAVE: next_state = core.stack_done ? mis_pkg::MIS_MASK : mis_pkg::MIS_SAVE;
			mis_pkg::MIS_MASK: next_state = mis_pkg::MIS_FETCH;
			mis_pkg::MIS_FETCH: next_state = core.vec_done ? mis_pkg::MIS_IDLE : mis_pkg::MIS_FETCH;
			default: next_state = mis_pkg::MIS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state <= mis_pkg::MIS_IDLE;
			stack_save_req <= 1'b0;
			vec_valid <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			stack_save_req <= next_state == mis_pkg::MIS_SAVE;
			vec_valid <= next_state == mis_pkg::MIS_FETCH;
		end
	end

	// vector frozen from selection until fetch completes
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			cur_vn <= 4'h0;
			cur_trap <= 1'b0;
			vec_addr <= `MIS_VEC_RESET;
		end else if (clk_en) begin
			if (take) begin
				cur_trap <= core.trap_exec;
				cur_vn <= sel_vn;
				vec_addr <= core.trap_exec ? `MIS_VEC_TRAP :
					`MIS_VEC_BASE - {11'h000, sel_vn, 1'b0};
			end
		end
	end

	// mask set at reset; entry sets it; return clears it
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			global_mask <= `MIS_RST_MASK;
		end else if (clk_en) begin
			if (state == mis_pkg::MIS_MASK) begin
				global_mask <= 1'b1;
			end else if (core.return_from_interrupt) begin
				global_mask <= 1'b0;
			end else if (wr_ctrl) begin
				global_mask <= hwdata[`MIS_CTRL_MASK_BIT];
			end
		end
	end

	always_comb begin
		case (power_mode)
			mis_pkg::MIS_WAIT: wake_ok = `MIS_WAKE_WAIT;
			mis_pkg::MIS_HALT: wake_ok = `MIS_WAKE_HALT;
			mis_pkg::MIS_AHALT: wake_ok = `MIS_WAKE_AHALT;
			mis_pkg::MIS_AUTO_WAKEUP_FROM_HALT_MODE: wake_ok = `MIS_WAKE_AUTO_WAKEUP_FROM_HALT_MODE;
			default: wake_ok = 14'h0000;
		endcase
		// falling-edge external two cannot leave the halt modes
		if (power_mode != mis_pkg::MIS_WAIT && !ext2_rise) begin
			wake_ok[`MIS_VN_EI2] = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			wake <= 1'b0;
		end else if (clk_en) begin
			wake <= |(req_vec & wake_ok);
		end
	end

	logic seen_run;
	always_ff @(posedge ref_clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			seen_run <= 1'b0;
		end else if (clk_en) begin
			seen_run <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_sync || !clk_en);

	a_mask_reset: assert property (!seen_run |-> global_mask)
		else $error("mask not set after reset");
	a_masked_hold: assert property (state == mis_pkg::MIS_IDLE && global_mask &&
		!core.trap_exec |=> !stack_save_req)
		else $error("masked request taken");
	a_trap_entry: assert property (state == mis_pkg::MIS_IDLE && core.instr_boundary &&
		core.trap_exec |=> stack_save_req ##0 vec_addr == `MIS_VEC_TRAP)
		else $error("trap not entered");
	a_entry_order: assert property (stack_save_req && core.stack_done |=>
		!stack_save_req ##1 global_mask && vec_valid)
		else $error("entry sequence out of order");
	a_return_unmask: assert property (core.return_from_interrupt &&
		state != mis_pkg::MIS_MASK |=> !global_mask)
		else $error("mask left set after return");
	a_vec_hold: assert property (vec_valid && !core.vec_done |=>
		vec_valid && $stable(vec_addr))
		else $error("vector changed before fetch");
	a_vec_range: assert property (vec_valid |-> !vec_addr[0] && vec_addr >= `MIS_VEC_LOW)
		else $error("vector outside table");
	a_prio_pick: assert property (take && !core.trap_exec |=>
		($past(req_vec) & ((14'h0001 << cur_vn) - 14'h0001)) == 14'h0000)
		else $error("lower priority source chosen");
	a_port_block: assert property (|(blk_s2 & ~ext_pend) |=>
		(ext_pend & $past(blk_s2 & ~ext_pend)) == '0)
		else $error("blocked source latched");
	a_latch_clear: assert property (|(ext_clr & ~ext_set) |=>
		(ext_pend & $past(ext_clr & ~ext_set)) == '0)
		else $error("external latch not cleared");
	a_wait_wake: assert property (power_mode == mis_pkg::MIS_WAIT &&
		|req_vec |=> wake)
		else $error("no wake from wait");
	a_halt_gate: assert property (power_mode == mis_pkg::MIS_HALT &&
		(req_vec & `MIS_WAKE_HALT) == 14'h0000 |=> !wake)
		else $error("illegal wake from halt");

	c_trap: cover property (take && core.trap_exec ##[1:20] core.vec_done);
	c_int: cover property (take && !core.trap_exec ##[1:20] core.vec_done);
	c_halt_wake: cover property (power_mode == mis_pkg::MIS_HALT && wake);
endmodule : mis_seq

// *** test/mis_core_model.sv ***
// Core sequencer model that answers the interrupt entry handshake
`timescale 1ns/1ps
module mis_core_model (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic slow,
	input wire logic trap_req,
	input wire logic return_from_interrupt_req,
	input wire logic stack_save_req,
	input wire logic vec_valid,
	output mis_pkg::mis_core_s core
);
	logic [2:0] tick;
	logic [3:0] cnt;
	logic trap_due;
	logic sent;
	logic busy;
	assign busy = stack_save_req || vec_valid;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tick <= 3'h0;
			cnt <= 4'h0;
			trap_due <= 1'b0;
			sent <= 1'b0;
			core <= '0;
		end else begin
			tick <= tick + 3'h1;
			core <= '0;
			core.return_from_interrupt <= return_from_interrupt_req;
			if (trap_req) begin
				trap_due <= 1'b1;
			end
			// boundaries only while running; a trap rides on one
			if (run && !busy && tick[1:0] == 2'h3 && (!slow || tick[2])) begin
				core.instr_boundary <= 1'b1;
				core.trap_exec <= trap_due || trap_req;
				trap_due <= 1'b0;
			end
			// push acknowledged before the fetch; a slow core stalls longer
			if (busy && !sent) begin
				cnt <= cnt + 4'h1;
				if (cnt == (slow ? 4'h9 : 4'h1)) begin
					core.stack_done <= stack_save_req;
					core.vec_done <= vec_valid && !stack_save_req;
					sent <= 1'b1;
					cnt <= 4'h0;
				end
			end else if (!busy) begin
				sent <= 1'b0;
			end
		end
	end
endmodule : mis_core_model

// *** test/mis_seq_tb_top.sv ***
// Bench for the interrupt sequencer: bus, vectors and wake
`timescale 1ns/1ps
`include "mis_map.svh"
module mis_seq_tb_top;
	localparam logic [7:0] a_ctrl = `MIS_OFF_CTRL;
	localparam logic [7:0] a_sens = `MIS_OFF_SENS;
	localparam logic [7:0] a_pen = `MIS_OFF_PEN;
	localparam logic [7:0] a_pend = `MIS_OFF_PEND;
	logic ref_clk, rstn, hsel, hwrite, trap_req, return_from_interrupt_req, slow, clk_en;
	logic rd_dp = 1'b0;
	logic vec_seen = 1'b0;
	logic hreadyout, hresp, global_mask, stack_save_req, vec_valid, wake;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [15:0] vec_addr;
	logic [4:0] ext_irq_pin, port_low_pin;
	logic [5:0] periph_flag, periph_clr;
	logic [10:0] pend;
	mis_pkg::mis_core_s core;
	mis_pkg::mis_mode_e power_mode;
	logic [31:0] exp_rd[$];
	logic [15:0] exp_vec[$];
	int n_errors, cmp_count;
	int k;
	// Vector number of each pending bit: externals, then peripherals
	int vn[11] = '{1, 2, 3, 5, 6, 0, 7, 8, 9, 10, 11};
	// Pending bits allowed to wake each power mode
	logic [10:0] wtab[5] = '{11'h000, 11'h7ff, 11'h00f, 11'h51f, 11'h02f};
	mis_seq i_mis_seq (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.core(core), .power_mode(power_mode), .ext_irq_pin(ext_irq_pin),
		.port_low_pin(port_low_pin), .periph_flag(periph_flag), .periph_clr(periph_clr),
		.global_mask(global_mask), .stack_save_req(stack_save_req),
		.vec_valid(vec_valid), .vec_addr(vec_addr), .wake(wake));
	mis_core_model i_mis_core_model (.ref_clk(ref_clk), .rstn(rstn),
		.run(power_mode == mis_pkg::MIS_RUN), .slow(slow), .trap_req(trap_req),
		.return_from_interrupt_req(return_from_interrupt_req), .stack_save_req(stack_save_req), .vec_valid(vec_valid),
		.core(core));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// Address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		if (!wr) exp_rd.push_back(e);
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e);
	endtask : rd
	// Two real changes of every field, so all external pendings drop
	task automatic clr_ext(input logic [9:0] s);
		wr(a_sens, {22'h0, s ^ 10'h3ff});
		wr(a_sens, {22'h0, s});
	endtask : clr_ext
	task automatic ret();
		return_from_interrupt_req <= 1'b1;
		cyc(1);
		return_from_interrupt_req <= 1'b0;
	endtask : ret
	task automatic entry_done();
		int i;
		for (i = 0; i < 300 && vec_valid !== 1'b1; i++) cyc(1);
		check("vec_valid", vec_valid, 32'h1);
		for (i = 0; i < 300 && vec_valid === 1'b1; i++) cyc(1);
		check("vec_valid", vec_valid, 32'h0);
	endtask : entry_done
	// Pending bit with the lowest vector number
	function automatic int best(input logic [10:0] pb);
		int b;
		b = 0;
		for (int i = 0; i < 11; i++) if (pb[i] && (!pb[b] || vn[i] < vn[b])) b = i;
		return b;
	endfunction : best
	function automatic logic [15:0] vaddr(input logic [10:0] pb);
		return 16'hfffa - 16'(2 * vn[best(pb)]);
	endfunction : vaddr
	// Each result is paired with the oldest note of its kind
	always @(posedge ref_clk) begin
		if (rd_dp && hreadyout === 1'b1) begin
			check("hrdata", hrdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
			check("hresp", hresp, 32'h0);
		end
		if (hreadyout === 1'b1) rd_dp = hsel && htrans[1] && !hwrite;
		if (vec_valid === 1'b1 && !vec_seen) begin
			check("global_mask", global_mask, 32'h1);
			check("stack_save_req", stack_save_req, 32'h0);
			check("vec_addr", vec_addr, exp_vec.size() ? exp_vec.pop_front() : 16'hx);
		end
		vec_seen = vec_valid === 1'b1;
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_errors++;
		test_done();
	end
	initial begin
		void'($urandom(26));
		{rstn, hsel, hwrite, trap_req, return_from_interrupt_req, slow} = 6'h0;
		clk_en = 1'b1;
		{haddr, hwdata, htrans, ext_irq_pin, periph_flag, periph_clr} = '0;
		port_low_pin = 5'h1f;
		power_mode = mis_pkg::MIS_RUN;
		n_errors = 0;
		cmp_count = 0;
		cyc(6);
		rstn <= 1'b1;
		cyc(6);
		check("global_mask", global_mask, 32'h1);
		check("vec_addr", vec_addr, 32'hfffe);
		rd(a_ctrl, 32'h1);
		rd(8'h40, 32'h0);
		// Idle-low pins would raise level requests once the mask clears
		clr_ext(10'h155);
		exp_vec.push_back(16'hfffc);
		slow <= 1'b1;
		trap_req <= 1'b1;
		cyc(1);
		trap_req <= 1'b0;
		entry_done();
		ret();
		cyc(3);
		check("global_mask", global_mask, 32'h0);
		wr(a_sens, 32'h3ff);
		rd(a_sens, 32'h155);
		wr(a_ctrl, 32'h1);
		// every trigger code on source zero, both edges
		for (int c = 0; c < 4; c++) begin
			ext_irq_pin[0] <= 1'b0;
			cyc(5);
			clr_ext({8'h55, c[1:0]});
			ext_irq_pin[0] <= 1'b1;
			cyc(6);
			rd(a_pend, {31'h0, c != 2});
			clr_ext({8'h55, c[1:0]});
			rd(a_pend, 32'h0);
			ext_irq_pin[0] <= 1'b0;
			cyc(6);
			rd(a_pend, {31'h0, c != 1});
		end
		clr_ext(10'h155);
		port_low_pin[1] <= 1'b0;
		ext_irq_pin[1] <= 1'b1;
		cyc(6);
		rd(a_pend, 32'h0);
		ext_irq_pin[1] <= 1'b0;
		cyc(4);
		port_low_pin[1] <= 1'b1;
		pend = {6'($urandom()) | 6'h1, 5'($urandom())};
		wr(a_pen, 32'h0);
		periph_flag <= pend[10:5];
		cyc(2);
		periph_flag <= 6'h0;
		wr(a_ctrl, 32'h0);
		cyc(12);
		rd(a_pend, {21'h0, pend[10:5], 5'h0});
		wr(a_ctrl, 32'h1);
		wr(a_pen, 32'h3f);
		ext_irq_pin <= pend[4:0];
		cyc(6);
		exp_vec.push_back(vaddr(pend));
		wr(a_ctrl, 32'h0);
		while (pend != 11'h0) begin
			entry_done();
			k = best(pend);
			pend[k] = 1'b0;
			if (k > 5 && k[0]) begin
				periph_clr[k - 5] <= 1'b1;
				cyc(1);
				periph_clr <= 6'h0;
			end else if (k >= 5) begin
				wr(a_pend, 32'h7ff & ~(32'h1 << k));
			end
			rd(a_pend, {21'h0, pend});
			if (pend != 11'h0) exp_vec.push_back(vaddr(pend));
			slow <= 1'($urandom());
			ret();
		end
		wr(a_ctrl, 32'h1);
		ext_irq_pin <= 5'h0;
		cyc(5);
		clr_ext(10'h155);
		for (int s = 0; s < 11; s++) begin
			power_mode <= mis_pkg::MIS_HALT;
			if (s < 5) ext_irq_pin[s] <= 1'b1;
			else periph_flag[s - 5] <= 1'b1;
			cyc(6);
			periph_flag <= 6'h0;
			for (int m = 1; m < 5; m++) begin
				power_mode <= mis_pkg::mis_mode_e'(m);
				cyc(3);
				check("wake", wake, wtab[m][s]);
			end
			power_mode <= mis_pkg::MIS_RUN;
			if (s < 5) clr_ext(10'h155);
			else wr(a_pend, 32'h7ff & ~(32'h1 << s));
		end
		clr_ext(10'h165);
		power_mode <= mis_pkg::MIS_HALT;
		ext_irq_pin[2] <= 1'b0;
		cyc(6);
		for (int m = 4; m > 0; m--) begin
			power_mode <= mis_pkg::mis_mode_e'(m);
			cyc(3);
			check("wake", wake, {31'h0, m == 1});
		end
		// Clock enable low freezes the wake output
		clk_en <= 1'b0;
		power_mode <= mis_pkg::MIS_HALT;
		cyc(4);
		check("wake", wake, 32'h1);
		clk_en <= 1'b1;
		cyc(3);
		check("wake", wake, 32'h0);
		check("vectors left", exp_vec.size(), 32'h0);
		test_done();
	end
endmodule : mis_seq_tb_top
